//--- core/sapb_consts.svh
`ifndef SAPB_CONSTS_SVH
`define SAPB_CONSTS_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define SAPB_IDX_CORE_POWER 7'h28
`define SAPB_IDX_CORE_SLOPE 7'h29
`define SAPB_IDX_FE_POWER 7'h30
`define SAPB_IDX_REF_POWER 7'h40
`define SAPB_IDX_REF_TRIM 7'h41
`define SAPB_IDX_FE_TRIM 7'h42
`define SAPB_IDX_COLSEL_TRIM 7'h43

// ************************************************************
// reset values
// ************************************************************
`define SAPB_RST_CORE_POWER 16'h0000
`define SAPB_RST_CORE_SLOPE 16'h0b5a
`define SAPB_RST_FE_POWER 16'h0000
`define SAPB_RST_REF_POWER 16'h0000
`define SAPB_RST_REF_TRIM 16'h888b
`define SAPB_RST_FE_TRIM 16'h53c8
`define SAPB_RST_COLSEL_TRIM 16'h8888

// ************************************************************
// implemented bits of each word, the rest read as zero
// ************************************************************
`define SAPB_MSK_CORE_POWER 16'h0007
`define SAPB_MSK_CORE_SLOPE 16'hffff
`define SAPB_MSK_FE_POWER 16'h0001
`define SAPB_MSK_REF_POWER 16'h0001
`define SAPB_MSK_REF_TRIM 16'hffff
`define SAPB_MSK_FE_TRIM 16'h7fff
`define SAPB_MSK_COLSEL_TRIM 16'hffff

// ************************************************************
// field positions
// ************************************************************
`define SAPB_BIT_CORE_PWR 0
`define SAPB_BIT_MUX_PWR 1
`define SAPB_BIT_COLBIAS_EN 2
`define SAPB_FLD_DS_LO 0
`define SAPB_FLD_TS_LO 4
`define SAPB_BIT_FE_PWR 0
`define SAPB_BIT_BANDGAP_PWR 0
`define SAPB_BIT_EXTRES 0
`define SAPB_FLD_PRECHG_LO 4
`define SAPB_FLD_COLBIAS_LO 8
`define SAPB_FLD_PUMP_LO 12
`define SAPB_FLD_FECUR_LO 0
`define SAPB_FLD_CONVREF_LO 4
`define SAPB_FLD_AMPREF_LO 8
`define SAPB_FLD_STAGE1_LO 0
`define SAPB_FLD_STAGE2_LO 4
`define SAPB_TRIM_W 4
`define SAPB_AMPREF_W 7

// ************************************************************
// bus answers
// ************************************************************
`define SAPB_RESP_OKAY 2'h0
`define SAPB_RESP_DECERR 2'h3
`define SAPB_RDATA_PAD 16'h0000

`endif

//--- core/sapb_pkg.sv
`default_nettype none

package sapb_pkg;

    localparam int SAPB_NREGS = 7;
    localparam int SAPB_WORD_W = 16;
    localparam int SAPB_IDX_W = 7;

    typedef logic [SAPB_WORD_W-1:0] sapb_word_t;
    typedef logic [SAPB_NREGS-1:0] sapb_sel_t;

    typedef enum logic [1:0] {
        SAPB_ST_IDLE = 2'b01,
        SAPB_ST_ANSWER = 2'b10
    } sapb_state_e;

endpackage : sapb_pkg

`default_nettype wire

//--- core/sapb_regs.sv
// Chosen here: the Avalon-MM register port.
`default_nettype none
`include "sapb_consts.svh"

// How it works
// - word0 bit1 powers column multiplexer up/down
// - word0 bit2 enables column bias
// - slope word bits 3:0 double-slope level, reset 0xA
// - slope word bits 7:4 triple-slope level, reset 0x5
// - front-end word bit0 powers eight converters
// - bias power bit0 powers bandgap reference
// - trim bit0 selects external resistor, reset 1
// - precharge, column bias, pump trims, each 0x8
// - front-end, converter and amplifier reference trims
// - multiplexer stage one and two trims
// - word0 bit0 powers the image core
module sapb_regs
    import sapb_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    output logic image_core_power_up,
    output logic column_mux_power_up,
    output logic column_bias_enable,
    output logic [3:0] double_slope_level,
    output logic [3:0] triple_slope_level,
    output logic frontend_power_up,
    output logic bandgap_power_up,
    output logic external_resistor_select,
    output logic [3:0] column_precharge_trim,
    output logic [3:0] column_bias_trim,
    output logic [3:0] pump_current_trim,
    output logic [3:0] frontend_current_trim,
    output logic [3:0] converter_reference_trim,
    output logic [6:0] amplifier_reference_trim,
    output logic [3:0] column_select_stage_one_trim,
    output logic [3:0] column_select_stage_two_trim
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // the highest index needs seven bits above the two byte bits
    if (ADDR_W < SAPB_IDX_W + 2) begin : g_addr_check
        $error("sapb_regs: ADDR_W too small for the register map");
    end

    // ************************************************************
    // register map tables
    // ************************************************************
    localparam logic [SAPB_IDX_W-1:0] IDX [SAPB_NREGS] = '{
        `SAPB_IDX_CORE_POWER, `SAPB_IDX_CORE_SLOPE, `SAPB_IDX_FE_POWER,
        `SAPB_IDX_REF_POWER, `SAPB_IDX_REF_TRIM, `SAPB_IDX_FE_TRIM,
        `SAPB_IDX_COLSEL_TRIM
    };
    localparam sapb_word_t RST [SAPB_NREGS] = '{
        `SAPB_RST_CORE_POWER, `SAPB_RST_CORE_SLOPE, `SAPB_RST_FE_POWER,
        `SAPB_RST_REF_POWER, `SAPB_RST_REF_TRIM, `SAPB_RST_FE_TRIM,
        `SAPB_RST_COLSEL_TRIM
    };
    localparam sapb_word_t MSK [SAPB_NREGS] = '{
        `SAPB_MSK_CORE_POWER, `SAPB_MSK_CORE_SLOPE, `SAPB_MSK_FE_POWER,
        `SAPB_MSK_REF_POWER, `SAPB_MSK_REF_TRIM, `SAPB_MSK_FE_TRIM,
        `SAPB_MSK_COLSEL_TRIM
    };

    // slots in the tables above
    localparam int R_CORE_POWER = 0;
    localparam int R_CORE_SLOPE = 1;
    localparam int R_FE_POWER = 2;
    localparam int R_REF_POWER = 3;
    localparam int R_REF_TRIM = 4;
    localparam int R_FE_TRIM = 5;
    localparam int R_COLSEL_TRIM = 6;

    // ************************************************************
    // decode helpers
    // ************************************************************
    // one-hot select; all zero when the address hits no register
    // or is not word aligned
    function automatic sapb_sel_t decode(input logic [ADDR_W-1:0] a);
        sapb_sel_t s;
        s = '0;
        for (int i = 0; i < SAPB_NREGS; i++) begin
            if (a[1:0] == 2'b00 &&
                a[ADDR_W-1:2] == (ADDR_W-2)'(IDX[i])) begin
                s[i] = 1'b1;
            end
        end
        return s;
    endfunction : decode

    function automatic sapb_word_t pick(input sapb_sel_t s,
                                        input sapb_word_t w [SAPB_NREGS]);
        sapb_word_t r;
        r = '0;
        for (int i = 0; i < SAPB_NREGS; i++) begin
            if (s[i]) begin
                r = w[i];
            end
        end
        return r;
    endfunction : pick

    // ************************************************************
    // bus handshake
    // ************************************************************
    sapb_state_e state_q;
    sapb_sel_t sel_q;
    logic write_q;
    logic [1:0] be_q;
    sapb_word_t wdata_q;
    sapb_word_t word [SAPB_NREGS];
    logic [SAPB_NREGS-1:0] we;

    // every access costs one wait cycle: the request is caught first,
    // then answered; read data is decoded from the live address at that catching edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= SAPB_ST_IDLE;
        end else begin
            unique case (state_q)
                SAPB_ST_IDLE: begin
                    if (read || write) begin
                        state_q <= SAPB_ST_ANSWER;
                    end
                end
                SAPB_ST_ANSWER: begin
                    state_q <= SAPB_ST_IDLE;
                end
                default: begin
                    state_q <= SAPB_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_q <= '0;
            write_q <= 1'b0;
            be_q <= 2'b00;
            wdata_q <= '0;
        end else if (state_q == SAPB_ST_IDLE && (read || write)) begin
            sel_q <= decode(address);
            write_q <= write;
            be_q <= byteenable[1:0];
            wdata_q <= writedata[15:0];
        end
    end

    // waitrequest drops for exactly the answer cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !(state_q == SAPB_ST_IDLE && (read || write));
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readdata <= '0;
            response <= `SAPB_RESP_OKAY;
        end else if (state_q == SAPB_ST_IDLE && (read || write)) begin
            // unmapped reads return zero with a decode error
            readdata <= {`SAPB_RDATA_PAD,
                         read ? pick(decode(address), word) : 16'h0000};
            response <= (decode(address) == '0) ? `SAPB_RESP_DECERR
                                                : `SAPB_RESP_OKAY;
        end
    end

    // ************************************************************
    // register words
    // ************************************************************
    // the write lands at the edge where waitrequest is seen low
    assign we = (state_q == SAPB_ST_ANSWER && write_q) ? sel_q : '0;

    for (genvar i = 0; i < SAPB_NREGS; i++) begin : g_word
        // stores every documented field, reserved ones too
        sapb_regword #(
            .RESET(RST[i]),
            .MASK(MSK[i])
        ) u_word (
            .clk(clk),
            .resetn(resetn),
            .we(we[i]),
            .be(be_q),
            .wdata(wdata_q),
            .q(word[i])
        );
    end

    // ************************************************************
    // control outputs, straight from the register flops
    // ************************************************************
    // reserved fields are written back as read; the block does not
    // police them, but they drive no control output, so a careless write stays off the analog side
    always_comb begin
        image_core_power_up =
            word[R_CORE_POWER][`SAPB_BIT_CORE_PWR];
        column_mux_power_up =
            word[R_CORE_POWER][`SAPB_BIT_MUX_PWR];
        column_bias_enable =
            word[R_CORE_POWER][`SAPB_BIT_COLBIAS_EN];
        double_slope_level = word[R_CORE_SLOPE]
            [`SAPB_FLD_DS_LO +: `SAPB_TRIM_W];
        triple_slope_level = word[R_CORE_SLOPE]
            [`SAPB_FLD_TS_LO +: `SAPB_TRIM_W];
        frontend_power_up =
            word[R_FE_POWER][`SAPB_BIT_FE_PWR];
        bandgap_power_up =
            word[R_REF_POWER][`SAPB_BIT_BANDGAP_PWR];
        external_resistor_select =
            word[R_REF_TRIM][`SAPB_BIT_EXTRES];
        column_precharge_trim = word[R_REF_TRIM]
            [`SAPB_FLD_PRECHG_LO +: `SAPB_TRIM_W];
        column_bias_trim = word[R_REF_TRIM]
            [`SAPB_FLD_COLBIAS_LO +: `SAPB_TRIM_W];
        pump_current_trim = word[R_REF_TRIM]
            [`SAPB_FLD_PUMP_LO +: `SAPB_TRIM_W];
        frontend_current_trim = word[R_FE_TRIM]
            [`SAPB_FLD_FECUR_LO +: `SAPB_TRIM_W];
        converter_reference_trim = word[R_FE_TRIM]
            [`SAPB_FLD_CONVREF_LO +: `SAPB_TRIM_W];
        amplifier_reference_trim = word[R_FE_TRIM]
            [`SAPB_FLD_AMPREF_LO +: `SAPB_AMPREF_W];
        column_select_stage_one_trim = word[R_COLSEL_TRIM]
            [`SAPB_FLD_STAGE1_LO +: `SAPB_TRIM_W];
        column_select_stage_two_trim = word[R_COLSEL_TRIM]
            [`SAPB_FLD_STAGE2_LO +: `SAPB_TRIM_W];
    end

endmodule : sapb_regs

`default_nettype wire

//--- core/sapb_regword.sv
`default_nettype none

module sapb_regword
    import sapb_pkg::*;
#(
    parameter sapb_word_t RESET = 16'h0000,
    parameter sapb_word_t MASK = 16'hffff
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic we,
    input wire logic [1:0] be,
    input wire sapb_word_t wdata,
    output sapb_word_t q
);

    // ************************************************************
    // byte-lane merge
    // ************************************************************
    function automatic sapb_word_t merge(input sapb_word_t old,
                                         input sapb_word_t nw,
                                         input logic [1:0] lanes);
        sapb_word_t r;
        r = old;
        if (lanes[0]) begin
            r[7:0] = nw[7:0];
        end
        if (lanes[1]) begin
            r[15:8] = nw[15:8];
        end
        return r & MASK;
    endfunction : merge

    // unimplemented bits never hold a one, so they read back as zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= RESET & MASK;
        end else if (we) begin
            q <= merge(q, wdata, be);
        end
    end

endmodule : sapb_regword

`default_nettype wire

//--- sim/sapb_regs_asserts.sv
`default_nettype none
`include "sapb_consts.svh"

module sapb_regs_asserts
    import sapb_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [1:0] response,
    input wire logic image_core_power_up,
    input wire logic column_mux_power_up,
    input wire logic column_bias_enable,
    input wire logic [3:0] double_slope_level,
    input wire logic [3:0] triple_slope_level,
    input wire logic frontend_power_up,
    input wire logic bandgap_power_up,
    input wire logic external_resistor_select,
    input wire logic [3:0] column_precharge_trim,
    input wire logic [3:0] column_bias_trim,
    input wire logic [3:0] pump_current_trim,
    input wire logic [3:0] frontend_current_trim,
    input wire logic [3:0] converter_reference_trim,
    input wire logic [6:0] amplifier_reference_trim,
    input wire logic [3:0] column_select_stage_one_trim,
    input wire logic [3:0] column_select_stage_two_trim
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ************************************************************
    // accepted accesses and where they land
    // ************************************************************
    wire logic [6:0] ix = address[8:2];
    wire logic taken = !waitrequest && (read || write);
    wire logic ok_a = address[1:0] == 2'b00 && address[ADDR_W-1:9] == 1'b0;
    wire logic hit = ok_a && ix inside {`SAPB_IDX_CORE_POWER,
        `SAPB_IDX_CORE_SLOPE, `SAPB_IDX_FE_POWER, `SAPB_IDX_REF_POWER,
        `SAPB_IDX_REF_TRIM, `SAPB_IDX_FE_TRIM, `SAPB_IDX_COLSEL_TRIM};
    wire logic lo = taken && write && ok_a && byteenable[0];
    wire logic hi = taken && write && ok_a && byteenable[1];

    a_wait_single: assert property (
        !waitrequest |=> waitrequest)
        else $error("waitrequest low for two cycles");
    a_answer_next: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    a_resp_code: assert property (
        taken |-> response == (hit ? `SAPB_RESP_OKAY : `SAPB_RESP_DECERR)
        && (hit || readdata == 32'h0000_0000))
        else $error("wrong response code or data");
    a_core_power: assert property (
        lo && ix == `SAPB_IDX_CORE_POWER |=> {column_bias_enable,
        column_mux_power_up, image_core_power_up} == $past(writedata[2:0]))
        else $error("core power bits not taken from write");
    a_slope_word: assert property (
        lo && ix == `SAPB_IDX_CORE_SLOPE |=> {triple_slope_level,
        double_slope_level} == $past(writedata[7:0]))
        else $error("slope levels not taken from write");
    a_fe_power: assert property (
        lo && ix == `SAPB_IDX_FE_POWER |=>
        frontend_power_up == $past(writedata[0]))
        else $error("front-end power bit not taken from write");
    a_ref_trim: assert property (
        hi && ix == `SAPB_IDX_REF_TRIM |=> {pump_current_trim,
        column_bias_trim} == $past(writedata[15:8]))
        else $error("reference trims not taken from write");
    a_amp_trim: assert property (
        hi && ix == `SAPB_IDX_FE_TRIM |=>
        amplifier_reference_trim == $past(writedata[14:8]))
        else $error("amplifier trim not taken from write");
    a_colsel_trim: assert property (
        lo && ix == `SAPB_IDX_COLSEL_TRIM |=> {column_select_stage_two_trim,
        column_select_stage_one_trim} == $past(writedata[7:0]))
        else $error("column select trims not taken from write");

    c_ref_write: cover property (hi && ix == `SAPB_IDX_REF_TRIM);
    c_refused: cover property (taken && !hit);
    c_back_to_back: cover property (taken ##2 taken);

endmodule : sapb_regs_asserts

bind sapb_regs sapb_regs_asserts #(.ADDR_W(ADDR_W)) sapb_regs_asserts_inst (.*);

`default_nettype wire

//--- sim/test_sensor_analog_power_bias_regs.sv
`default_nettype none
`include "sapb_consts.svh"

module test_sensor_analog_power_bias_regs
    import sapb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0;
    logic [9:0] address = 10'h000;
    logic [31:0] writedata = 32'h0000_0000, readdata;
    logic [3:0] byteenable = 4'h0;
    logic [1:0] response;
    logic waitrequest, image_core_power_up, column_mux_power_up;
    logic column_bias_enable, frontend_power_up, bandgap_power_up;
    logic external_resistor_select;
    logic [3:0] double_slope_level, triple_slope_level, column_precharge_trim;
    logic [3:0] column_bias_trim, pump_current_trim, frontend_current_trim;
    logic [3:0] converter_reference_trim, column_select_stage_one_trim;
    logic [3:0] column_select_stage_two_trim;
    logic [6:0] amplifier_reference_trim;
    int mismatches = 0;
    int n_compared = 0;
    sapb_word_t m [7];
    logic [6:0] ix [7] = '{`SAPB_IDX_CORE_POWER, `SAPB_IDX_CORE_SLOPE,
        `SAPB_IDX_FE_POWER, `SAPB_IDX_REF_POWER, `SAPB_IDX_REF_TRIM,
        `SAPB_IDX_FE_TRIM, `SAPB_IDX_COLSEL_TRIM};
    sapb_word_t rst [7] = '{`SAPB_RST_CORE_POWER, `SAPB_RST_CORE_SLOPE,
        `SAPB_RST_FE_POWER, `SAPB_RST_REF_POWER, `SAPB_RST_REF_TRIM,
        `SAPB_RST_FE_TRIM, `SAPB_RST_COLSEL_TRIM};
    sapb_word_t msk [7] = '{`SAPB_MSK_CORE_POWER, `SAPB_MSK_CORE_SLOPE,
        `SAPB_MSK_FE_POWER, `SAPB_MSK_REF_POWER, `SAPB_MSK_REF_TRIM,
        `SAPB_MSK_FE_TRIM, `SAPB_MSK_COLSEL_TRIM};
    sapb_word_t pat [3] = '{16'hffff, 16'h0000, 16'ha5c3};

    sapb_regs sapb_regs_inst (.*);

    always #2.5 clk = ~clk;

    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [63:0] e,
                       input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : chk

    // the request is left standing: the caller either starts the next
    // access at once or calls idle_fields, so no strobe is driven twice
    task automatic acc(input logic is_rd, input logic [9:0] a,
                       input sapb_word_t d, input logic [1:0] be,
                       input logic [1:0] rsp);
        int n;
        read <= is_rd;
        write <= !is_rd;
        address <= a;
        writedata <= {16'h0000, d};
        byteenable <= {2'b00, be};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            mismatches++;
            report_and_stop();
        end
        chk("response", 64'(rsp), 64'(response));
    endtask : acc

    task automatic wr(input int i, input sapb_word_t d, input logic [1:0] be);
        acc(1'b0, {1'b0, ix[i], 2'b00}, d, be, `SAPB_RESP_OKAY);
        if (be[0]) m[i][7:0] = d[7:0] & msk[i][7:0];
        if (be[1]) m[i][15:8] = d[15:8] & msk[i][15:8];
    endtask : wr

    task automatic rd(input int i);
        acc(1'b1, {1'b0, ix[i], 2'b00}, 16'h0000, 2'b00, `SAPB_RESP_OKAY);
        chk("readdata", {48'h0000_0000_0000, m[i]}, 64'(readdata));
    endtask : rd

    task automatic idle_fields();
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
        chk("fields", 64'({m[0][0], m[0][1], m[0][2], m[1][7:0], m[2][0],
            m[3][0], m[4][15:4], m[4][0], m[5][14:0], m[6][7:0]}),
            64'({image_core_power_up, column_mux_power_up, column_bias_enable,
            triple_slope_level, double_slope_level, frontend_power_up,
            bandgap_power_up, pump_current_trim, column_bias_trim,
            column_precharge_trim, external_resistor_select,
            amplifier_reference_trim, converter_reference_trim,
            frontend_current_trim, column_select_stage_two_trim,
            column_select_stage_one_trim}));
    endtask : idle_fields

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        m = rst;
        for (int i = 0; i < 7; i++) begin
            rd(i);
        end
        idle_fields();
        $display("test reset_values done");
        foreach (pat[p]) begin
            for (int i = 0; i < 7; i++) begin
                wr(i, pat[p], 2'b11);
                rd(i);
            end
            idle_fields();
        end
        $display("test patterns done");
        for (int i = 0; i < 7; i++) begin
            wr(i, 16'h1e2d, 2'b01);
            wr(i, 16'hc3b4, 2'b10);
            rd(i);
        end
        idle_fields();
        $display("test byte_lanes done");
        acc(1'b0, 10'h0a1, 16'hffff, 2'b11, `SAPB_RESP_DECERR);
        acc(1'b0, 10'h3fc, 16'hffff, 2'b11, `SAPB_RESP_DECERR);
        acc(1'b1, 10'h0a6, 16'h0000, 2'b00, `SAPB_RESP_DECERR);
        chk("refused readdata", 64'h0, 64'(readdata));
        idle_fields();
        $display("test refused done");
        rd(1);
        wr(1, {m[1][15:4], 4'h3}, 2'b11);
        rd(1);
        idle_fields();
        $display("test read_modify_write done");
        // a reset in mid-run must bring every field back at once
        resetn <= 1'b0;
        m = rst;
        idle_fields();
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(i);
        end
        idle_fields();
        $display("test mid_reset done");
        report_and_stop();
    end

endmodule : test_sensor_analog_power_bias_regs

`default_nettype wire
